//--- verilog/comon_pkg.sv
/*
  Constants and types for the gas monitor output control block.
  Assumes a 40 MHz system clock and a classic Wishbone register bus with
  32-bit data and byte addresses.
*/
package comon_pkg;

  // Clock and timing.
  localparam int CLK_HZ         = 40_000_000;
  localparam int HALF_SEC_MS    = 500;
  localparam int HALF_SEC_CYC   = (CLK_HZ / 1000) * HALF_SEC_MS;
  localparam int FAULT_MIN      = 10;
  localparam int FAULT_SEC      = FAULT_MIN * 60;
  localparam int LT_STEP_SEC    = 5;
  localparam int LT_STEP_HALVES = LT_STEP_SEC * 2;
  localparam int RENEW_SEC      = 1;
  localparam int RENEW_HALVES   = RENEW_SEC * 2;
  localparam int ADJ_STEP_SEC   = 1;

  // Bias loop window and levels on the 8-bit conversion scale.
  localparam logic [7:0] WIN_LO     = 8'h19;
  localparam logic [7:0] WIN_HI     = 8'h33;
  localparam logic [7:0] BIAS_START = 8'h80;
  localparam logic [7:0] BIAS_MAX   = 8'hff;
  localparam logic [7:0] BIAS_MIN   = 8'h00;

  // Concentration scale in ppm.
  localparam logic [15:0] PPM_MIN  = 16'h0190;
  localparam logic [15:0] PPM_MAX  = 16'h0bb8;
  localparam logic [7:0]  DUTY_MAX = 8'hff;

  // Threshold select bands and open/close pairs in ppm.
  localparam logic [7:0]  SEL_B1 = 8'h30;
  localparam logic [7:0]  SEL_B2 = 8'h60;
  localparam logic [7:0]  SEL_B3 = 8'h90;
  localparam logic [7:0]  SEL_B4 = 8'hc0;
  localparam logic [15:0] OPEN0  = 16'h0320;
  localparam logic [15:0] CLOSE0 = 16'h02d0;
  localparam logic [15:0] OPEN1  = 16'h03e8;
  localparam logic [15:0] CLOSE1 = 16'h0320;
  localparam logic [15:0] OPEN2  = 16'h05dc;
  localparam logic [15:0] CLOSE2 = 16'h0514;
  localparam logic [15:0] OPEN3  = 16'h07d0;
  localparam logic [15:0] CLOSE3 = 16'h0708;
  localparam logic [15:0] OPEN4  = 16'h0bb8;
  localparam logic [15:0] CLOSE4 = 16'h0a8c;

  // Register byte offsets and fields.
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_CONC   = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_BIAS   = 8'h0c;
  localparam int CTRL_WARMUP  = 0;
  localparam int CTRL_RENEW   = 1;
  localparam int ST_FAULT     = 0;
  localparam int ST_SETTLED   = 1;
  localparam int ST_DAMPER    = 2;
  localparam int ST_LINE_TEST = 3;
  localparam int ST_STEP_LO   = 4;
  localparam int ST_REBASE    = 6;
  localparam logic       CTRL_WARMUP_RST = 1'b1;
  localparam logic [1:0] LT_STEP_LAST    = 2'h3;

  // Setting inputs read back during line test step 3.
  typedef struct packed {
    logic warmup;
    logic adj_level;
    logic adj_time;
    logic auto_reset;
  } comon_setting_t;

  // Output pins as a group.
  typedef struct packed {
    logic bias_pwm;
    logic conc_pwm;
    logic damper;
    logic fault;
    logic red_led;
    logic green_led;
    logic renewal;
  } comon_pins_t;

endpackage

//--- verilog/comon_output_ctrl.sv
/*
  Output control of a gas monitor: bias PWM loop, concentration PWM, damper
  output with hysteresis, LED patterns, fault timeout, renewal strobe, manual
  rebase and power-up line test, with registers on a classic Wishbone slave.
  Assumes all inputs are synchronous to clk_i and that the concentration in
  ppm is written by software from the arithmetic outside this block.
*/
`timescale 1ns/100ps
module comon_output_ctrl #(
  parameter int unsigned HALF_CYC = comon_pkg::HALF_SEC_CYC
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // Wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // Sensor side and straps
  input  wire logic [7:0]                gas_level_in,
  input  wire logic [7:0]                threshold_select_in,
  input  wire logic                      manual_rebase_in_n,
  input  wire logic                      line_test_in_n,
  input  wire comon_pkg::comon_setting_t setting_i,
  // Output pins
  output comon_pkg::comon_pins_t         pins_o
);

  initial begin
    if (HALF_CYC < 2) begin
      $error("HALF_CYC must be at least 2");
    end
  end

  typedef struct packed {
    logic [31:0] half_cnt;
    logic        blink;
    logic        sec_ph;
    logic [9:0]  adj_sec;
    logic [7:0]  bias;
    logic        settled;
    logic        fault;
    logic        damper_open;
    logic [31:0] renew_left;
    logic        rebase_prev;
    logic        line_test;
    logic        strap_done;
    logic [1:0]  lt_step;
    logic [3:0]  lt_half;
    logic [15:0] conc;
    logic        warmup;
    logic        rebase_seen;
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  pwm_cnt;
    comon_pkg::comon_pins_t pins;
  } comon_state_t;

  comon_state_t q;
  comon_state_t d;

  // Open threshold in the upper half, close threshold in the lower half.
  function automatic logic [31:0] thresholds(input logic [7:0] sel);
    if (sel <= comon_pkg::SEL_B1) begin
      return {comon_pkg::OPEN0, comon_pkg::CLOSE0};
    end else if (sel <= comon_pkg::SEL_B2) begin
      return {comon_pkg::OPEN1, comon_pkg::CLOSE1};
    end else if (sel <= comon_pkg::SEL_B3) begin
      return {comon_pkg::OPEN2, comon_pkg::CLOSE2};
    end else if (sel <= comon_pkg::SEL_B4) begin
      return {comon_pkg::OPEN3, comon_pkg::CLOSE3};
    end else begin
      return {comon_pkg::OPEN4, comon_pkg::CLOSE4};
    end
  endfunction

  // Linear duty from ppm, clamped to the 400..3000 ppm span.
  function automatic logic [7:0] ppm_duty(input logic [15:0] ppm);
    logic [31:0] scaled;
    scaled = 32'(ppm - comon_pkg::PPM_MIN) * 32'(comon_pkg::DUTY_MAX)
           / 32'(comon_pkg::PPM_MAX - comon_pkg::PPM_MIN);
    if (ppm <= comon_pkg::PPM_MIN) begin
      return 8'h00;
    end else if (ppm >= comon_pkg::PPM_MAX) begin
      return comon_pkg::DUTY_MAX;
    end else begin
      return scaled[7:0];
    end
  endfunction

  logic [15:0] open_th;
  logic [15:0] close_th;
  logic [31:0] th_pair;
  logic        half_tick;
  logic        sec_tick;
  logic        wb_req;
  logic        wb_wr;
  logic        rebase_edge;
  logic        renew_evt;
  logic        in_window;
  logic [7:0]  bias_duty;
  logic [7:0]  conc_duty;

  assign th_pair   = thresholds(threshold_select_in);
  assign open_th   = th_pair[31:16];
  assign close_th  = th_pair[15:0];
  assign half_tick = (q.half_cnt == 32'(HALF_CYC - 1));
  assign sec_tick  = half_tick && q.sec_ph;
  assign wb_req    = wb_cyc_i && wb_stb_i && !q.ack;
  assign wb_wr     = wb_req && wb_we_i;
  assign in_window = (gas_level_in >= comon_pkg::WIN_LO) && (gas_level_in <= comon_pkg::WIN_HI);
  assign rebase_edge = q.rebase_prev && !manual_rebase_in_n;
  assign renew_evt = !q.line_test && (rebase_edge ||
                     (wb_wr && wb_adr_i == comon_pkg::ADR_CTRL && wb_sel_i[0] &&
                      wb_dat_i[comon_pkg::CTRL_RENEW]));

  always_comb begin
    d = q;
    d.half_cnt    = half_tick ? 32'h0 : q.half_cnt + 32'h1;
    d.pwm_cnt     = q.pwm_cnt + 8'h01;
    d.rebase_prev = manual_rebase_in_n;
    if (half_tick) begin
      d.blink  = !q.blink;
      d.sec_ph = !q.sec_ph;
    end
    // The strap is sampled on the first cycle after reset release.
    if (!q.strap_done) begin
      d.strap_done = 1'b1;
      d.line_test  = !line_test_in_n;
    end
    // Line test sequencer.
    if (q.line_test && half_tick && q.lt_step != comon_pkg::LT_STEP_LAST) begin
      if (q.lt_half == 4'(comon_pkg::LT_STEP_HALVES - 1)) begin
        d.lt_half = 4'h0;
        d.lt_step = q.lt_step + 2'h1;
      end else begin
        d.lt_half = q.lt_half + 4'h1;
      end
    end
    // Bias loop with the fault timeout; the bias freezes once faulted.
    if (!q.line_test && q.strap_done && !q.fault && sec_tick) begin
      if (in_window) begin
        d.settled = 1'b1;
      end else begin
        if (q.settled) begin
          d.adj_sec = 10'h000;
        end else begin
          d.adj_sec = q.adj_sec + 10'h001;
        end
        d.settled = 1'b0;
        if (gas_level_in > comon_pkg::WIN_HI && q.bias != comon_pkg::BIAS_MIN) begin
          d.bias = q.bias - 8'h01;
        end else if (gas_level_in < comon_pkg::WIN_LO &&
                     q.bias != comon_pkg::BIAS_MAX) begin
          d.bias = q.bias + 8'h01;
        end
        if (!q.settled && d.adj_sec == 10'(comon_pkg::FAULT_SEC)) begin
          d.fault = 1'b1;
        end
      end
    end
    // Damper hysteresis.
    if (q.warmup || d.fault) begin
      d.damper_open = 1'b0;
    end else if (q.conc > open_th) begin
      d.damper_open = 1'b1;
    end else if (q.conc < close_th) begin
      d.damper_open = 1'b0;
    end
    // Renewal strobe; a new renewal restarts the full second.
    if (renew_evt) begin
      d.renew_left  = 32'(comon_pkg::RENEW_HALVES * HALF_CYC);
      d.rebase_seen = 1'b1;
    end else if (q.renew_left != 32'h0) begin
      d.renew_left = q.renew_left - 32'h1;
    end
    // Register bus.
    d.ack   = wb_req;
    d.rdata = 32'h0;
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        comon_pkg::ADR_CTRL: d.rdata[comon_pkg::CTRL_WARMUP] = q.warmup;
        comon_pkg::ADR_CONC: d.rdata[15:0] = q.conc;
        comon_pkg::ADR_STATUS: begin
          d.rdata[comon_pkg::ST_FAULT]     = q.fault;
          d.rdata[comon_pkg::ST_SETTLED]   = q.settled;
          d.rdata[comon_pkg::ST_DAMPER]    = q.damper_open;
          d.rdata[comon_pkg::ST_LINE_TEST] = q.line_test;
          d.rdata[comon_pkg::ST_STEP_LO+:2] = q.lt_step;
          d.rdata[comon_pkg::ST_REBASE]    = q.rebase_seen;
        end
        comon_pkg::ADR_BIAS: d.rdata[7:0] = q.bias;
        default: d.rdata = 32'h0;
      endcase
    end
    if (wb_wr && wb_adr_i == comon_pkg::ADR_CTRL && wb_sel_i[0]) begin
      d.warmup = wb_dat_i[comon_pkg::CTRL_WARMUP];
    end
    if (wb_wr && wb_adr_i == comon_pkg::ADR_CONC) begin
      if (wb_sel_i[0]) begin
        d.conc[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        d.conc[15:8] = wb_dat_i[15:8];
      end
    end
    // Writing one clears the rebase flag unless a renewal lands now.
    if (wb_wr && wb_adr_i == comon_pkg::ADR_STATUS && wb_sel_i[0] &&
        wb_dat_i[comon_pkg::ST_REBASE] && !renew_evt) begin
      d.rebase_seen = 1'b0;
    end
    // Output pins, registered from the next state.
    bias_duty = d.bias;
    conc_duty = ppm_duty(d.conc);
    if (d.line_test) begin
      conc_duty = ppm_duty(open_th);
      case (d.lt_step)
        2'h0: begin
          bias_duty = comon_pkg::BIAS_MIN;
          d.pins.green_led = 1'b0;
          d.pins.red_led   = 1'b1;
          d.pins.damper    = 1'b1;
          d.pins.fault     = 1'b1;
          d.pins.renewal   = 1'b1;
        end
        2'h1: begin
          bias_duty = comon_pkg::BIAS_MAX;
          d.pins.green_led = 1'b1;
          d.pins.red_led   = 1'b0;
          d.pins.damper    = 1'b0;
          d.pins.fault     = 1'b0;
          d.pins.renewal   = 1'b0;
        end
        2'h2: begin
          bias_duty = comon_pkg::BIAS_START;
          d.pins.green_led = setting_i.warmup;
          d.pins.red_led   = setting_i.adj_level;
          d.pins.damper    = setting_i.adj_time;
          d.pins.fault     = setting_i.auto_reset;
          d.pins.renewal   = 1'b1;
        end
        default: begin
          bias_duty = comon_pkg::BIAS_START;
          d.pins.green_led = 1'b1;
          d.pins.red_led   = 1'b1;
          d.pins.damper    = 1'b1;
          d.pins.fault     = 1'b1;
          d.pins.renewal   = 1'b1;
        end
      endcase
    end else begin
      d.pins.damper  = !d.damper_open;
      d.pins.fault   = !d.fault;
      d.pins.renewal = (d.renew_left == 32'h0);
      if (d.fault) begin
        conc_duty = 8'h00;
        d.pins.red_led   = d.blink;
        d.pins.green_led = 1'b0;
      end else if (d.warmup) begin
        d.pins.red_led   = 1'b0;
        d.pins.green_led = d.blink;
      end else begin
        d.pins.red_led   = (d.conc > open_th);
        d.pins.green_led = !(d.conc > open_th);
      end
    end
    d.pins.bias_pwm = (d.pwm_cnt < bias_duty) || (bias_duty == comon_pkg::BIAS_MAX);
    d.pins.conc_pwm = (d.pwm_cnt < conc_duty) || (conc_duty == comon_pkg::DUTY_MAX);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.bias <= comon_pkg::BIAS_START;
      q.warmup <= comon_pkg::CTRL_WARMUP_RST;
      q.rebase_prev <= 1'b1;
      q.pins <= '0;
    end else begin
      q <= d;
    end
  end

  assign pins_o   = q.pins;
  assign wb_dat_o = q.rdata;
  assign wb_ack_o = q.ack;

  bias_start_a: assert property (@(posedge clk_i)
    $fell(rst_i) |-> q.bias == comon_pkg::BIAS_START)
    else $error("bias did not start at mid scale");

  fault_damper_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.fault && !q.line_test) |-> (pins_o.damper && !pins_o.conc_pwm && !pins_o.green_led))
    else $error("fault did not force damper and concentration outputs");

  fault_timeout_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.adj_sec == 10'(comon_pkg::FAULT_SEC) && !q.settled) |-> q.fault)
    else $error("adjustment timeout did not raise fault");

  bias_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    q.fault |=> $stable(q.bias))
    else $error("bias moved while faulted");

  renew_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (renew_evt && q.strap_done) |=> !pins_o.renewal [*2])
    else $error("renewal strobe not driven low");

  damper_hyst_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.damper_open && q.conc >= close_th && !q.warmup && !d.fault) |=> q.damper_open)
    else $error("damper closed above close threshold");

  led_normal_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!q.line_test && !q.fault && !q.warmup) |-> (pins_o.red_led == (q.conc > $past(open_th))
      && pins_o.green_led == !pins_o.red_led))
    else $error("normal led pattern wrong");

  step_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.line_test && q.lt_step == 2'h0) |-> (!pins_o.green_led && pins_o.red_led &&
      pins_o.damper && pins_o.fault && pins_o.renewal))
    else $error("line test step one pattern wrong");

  wb_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle after request");

endmodule

//--- test/comon_gas_model.sv
/*
  Gas front end model: filters the bias PWM over 256 clocks and returns a
  gas level of half the measured duty, or a fixed high level when told to
  stick. Assumes it shares the block's clock.
*/
`timescale 1ns/100ps
module comon_gas_model (
  // Clock
  input  wire logic       clk_i,
  // Bias from the block, stuck command from the bench
  input  wire logic       bias_pwm_i,
  input  wire logic       stuck_i,
  // Converted gas level
  output logic      [7:0] gas_level_o
);
  logic [7:0] cnt_q = 8'h00;
  logic [8:0] acc_q = 9'h000;
  logic [7:0] lvl_q = 8'h40;

  assign gas_level_o = lvl_q;

  // The level follows the filtered bias, so the loop can pull it into window.
  always @(posedge clk_i) begin
    cnt_q <= cnt_q + 8'h01;
    acc_q <= (cnt_q == 8'hff) ? 9'h000 : acc_q + 9'(bias_pwm_i);
    if (cnt_q == 8'hff)
      lvl_q <= stuck_i ? 8'hc8 : 8'((acc_q + 9'(bias_pwm_i)) >> 1);
  end
endmodule

//--- test/testbench.sv
/*
  Self-checking bench for the gas monitor output control block.
  Assumes a 40 MHz clock and a shortened half-second count.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  localparam int HC = 32;
  logic                      clk_i = 1'b0;
  logic                      rst_i = 1'b1;
  logic                      wb_cyc_i = 1'b0;
  logic                      wb_stb_i = 1'b0;
  logic                      wb_we_i = 1'b0;
  logic [7:0]                wb_adr_i = 8'h00;
  logic [3:0]                wb_sel_i = 4'hf;
  logic [31:0]               wb_dat_i = 32'h0;
  logic [31:0]               wb_dat_o;
  logic                      wb_ack_o;
  logic [7:0]                gas_level_in;
  logic [7:0]                threshold_select_in = 8'h00;
  logic                      manual_rebase_in_n = 1'b1;
  logic                      line_test_in_n = 1'b1;
  comon_pkg::comon_setting_t setting_i = 4'b1010;
  comon_pkg::comon_pins_t    pins_o;
  logic                      stuck = 1'b0;
  logic [31:0]               rd;
  int                        fail_count = 0;
  int                        tests_run = 0;

  always #12.5 clk_i = ~clk_i;

  comon_output_ctrl #(.HALF_CYC(HC)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .gas_level_in(gas_level_in), .threshold_select_in(threshold_select_in),
    .manual_rebase_in_n(manual_rebase_in_n), .line_test_in_n(line_test_in_n),
    .setting_i(setting_i), .pins_o(pins_o));
  comon_gas_model u_gas (.clk_i(clk_i), .bias_pwm_i(pins_o.bias_pwm), .stuck_i(stuck),
    .gas_level_o(gas_level_in));

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic give_up;
    fail_count++;
    report_and_stop();
  endtask

  task automatic do_reset(input logic lt_n);
    @(posedge clk_i);
    rst_i <= 1'b1;
    line_test_in_n <= lt_n; // Strap level at power-up.
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20 && wb_ack_o !== 1'b1)
      give_up();
  endtask

  task automatic conc(input logic [15:0] v);
    wb(1'b1, comon_pkg::ADR_CONC, {16'h0, v});
    repeat (2 * HC + 4) @(posedge clk_i);
  endtask

  // Counts the high cycles of one pin over a full PWM period.
  task automatic duty(input int b, output int n);
    n = 0;
    repeat (256) begin
      @(posedge clk_i);
      n += int'(pins_o[b]);
    end
  endtask

  task automatic t_reset;
    logic g;
    wb(1'b0, comon_pkg::ADR_CTRL, 32'h0);
    `CHK(rd, 32'h1)
    wb(1'b0, comon_pkg::ADR_BIAS, 32'h0);
    `CHK(rd, 32'h80)
    wb(1'b1, 8'h10, 32'hff);
    wb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b0, comon_pkg::ADR_STATUS, 32'h0);
    `CHK(rd[3], 1'b0)
    g = pins_o.green_led;
    repeat (HC) @(posedge clk_i);
    `CHK(pins_o.green_led, ~g)
    `CHK(pins_o[4:2], 3'b110)
  endtask

  task automatic t_bias;
    int n = 0;
    do begin
      wb(1'b0, comon_pkg::ADR_STATUS, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 1500);
    if (rd[1] !== 1'b1)
      give_up();
    repeat (600) @(posedge clk_i);
    wb(1'b0, comon_pkg::ADR_STATUS, 32'h0);
    `CHK(rd[1:0], 2'b10)
    wb(1'b0, comon_pkg::ADR_BIAS, 32'h0);
    `CHK(rd[7:1] >= 7'd25 && rd[7:1] <= 7'd51, 1'b1)
  endtask

  task automatic t_damper;
    logic [7:0]  sel [5] = '{8'd48, 8'd49, 8'd144, 8'd145, 8'd255};
    logic [15:0] opn [5] = '{16'd800, 16'd1000, 16'd1500, 16'd2000, 16'd3000};
    logic [15:0] cls [5] = '{16'd720, 16'd800, 16'd1300, 16'd1800, 16'd2700};
    int n;
    wb(1'b1, comon_pkg::ADR_CTRL, 32'h0);
    for (int i = 0; i < 5; i++) begin
      threshold_select_in <= sel[i];
      conc(opn[i]);
      `CHK(pins_o[4:1], 4'b1101)
      conc(opn[i] + 16'd1);
      `CHK(pins_o[4:1], 4'b0110)
      conc(cls[i]);
      `CHK(pins_o[4:1], 4'b0101)
      conc(cls[i] - 16'd1);
      `CHK(pins_o[4:1], 4'b1101)
    end
    conc(16'd3000);
    duty(5, n);
    `CHK(n, 256)
    conc(16'd400);
    duty(5, n);
    `CHK(n, 0)
  endtask

  task automatic t_renew;
    @(posedge clk_i);
    manual_rebase_in_n <= 1'b0; // Operator pulse in clean air.
    repeat (2) @(posedge clk_i);
    manual_rebase_in_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK(pins_o.renewal, 1'b0)
    repeat (2 * HC - 3) @(posedge clk_i);
    `CHK(pins_o.renewal, 1'b0)
    @(posedge clk_i);
    `CHK(pins_o.renewal, 1'b1)
    wb(1'b0, comon_pkg::ADR_STATUS, 32'h0);
    `CHK(rd[6], 1'b1)
    wb(1'b1, comon_pkg::ADR_STATUS, 32'h40);
    wb(1'b0, comon_pkg::ADR_STATUS, 32'h0);
    `CHK(rd[6], 1'b0)
    wb(1'b1, comon_pkg::ADR_CTRL, 32'h2);
    repeat (3) @(posedge clk_i);
    `CHK(pins_o.renewal, 1'b0)
    repeat (2 * HC - 4) @(posedge clk_i);
    `CHK(pins_o.renewal, 1'b0)
    @(posedge clk_i);
    `CHK(pins_o.renewal, 1'b1)
  endtask

  task automatic t_fault;
    logic r;
    int n;
    threshold_select_in <= 8'd0;
    conc(16'd3000);
    `CHK(pins_o.damper, 1'b0)
    stuck <= 1'b1;
    repeat (590 * 2 * HC) @(posedge clk_i);
    `CHK(pins_o.fault, 1'b1)
    repeat (30 * 2 * HC) @(posedge clk_i);
    `CHK({pins_o[4:3], pins_o[1]}, 3'b100)
    duty(5, n);
    `CHK(n, 0)
    r = pins_o.red_led;
    repeat (HC) @(posedge clk_i);
    `CHK(pins_o.red_led, ~r)
    wb(1'b0, comon_pkg::ADR_STATUS, 32'h0);
    `CHK(rd[0], 1'b1)
  endtask

  task automatic t_line;
    int n;
    stuck <= 1'b0;
    do_reset(1'b0);
    repeat (20) @(posedge clk_i);
    `CHK(pins_o[4:0], 5'b11101)
    duty(6, n);
    `CHK(n, 0)
    repeat (64) @(posedge clk_i);
    `CHK(pins_o[4:0], 5'b00010)
    duty(6, n);
    `CHK(n, 256)
    repeat (64) @(posedge clk_i);
    `CHK(pins_o[4:0], 5'b10011)
    duty(6, n);
    `CHK(n, 128)
    repeat (64) @(posedge clk_i);
    `CHK(pins_o[4:0], 5'b11111)
    duty(5, n);
    `CHK(n >= 38 && n <= 40, 1'b1)
    repeat (1000) @(posedge clk_i);
    `CHK(pins_o[4:0], 5'b11111)
    wb(1'b0, comon_pkg::ADR_STATUS, 32'h0);
    `CHK(rd[5:3], 3'b111)
  endtask

  initial begin
    do_reset(1'b1);
    t_reset();
    t_bias();
    t_damper();
    t_renew();
    t_fault();
    t_line();
    report_and_stop();
  end
endmodule
